// ### hw/sync_sram_input_capture.sv
`timescale 1ns/1ps
module sync_sram_input_capture (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [sram_capture_pkg::ADDR_W-1:0] addressPins,
   input wire logic [sram_capture_pkg::DATA_W-1:0] laneDataPins,
   input wire logic [sram_capture_pkg::LANES-1:0] laneParityPins,
   input wire logic [sram_capture_pkg::LANES-1:0] byteWriteLane_n,
   input wire logic chipSelectFirst_n,
   input wire logic chipSelectSecond,
   input wire logic chipSelectThird_n,
   input wire logic advanceLoad,
   input wire logic writeEnable_n,
   input wire logic clockEnable_n,
   output sram_capture_pkg::word_t capturedWord,
   output logic capturedValid,
   input wire logic capturedReady,
   output logic captureReady,
   output logic [sram_capture_pkg::BURST_W-1:0] burstCount,
   output logic selected
);
   typedef struct packed {
      logic [sram_capture_pkg::ADDR_W-1:0] addr;
      logic [sram_capture_pkg::DATA_W-1:0] data;
      logic [sram_capture_pkg::LANES-1:0] parity;
      logic [sram_capture_pkg::LANES-1:0] bw_n;
      logic cs1_n;
      logic cs2;
      logic cs3_n;
      logic advance_load;
      logic we_n;
      logic cke_n;
   } pins_t;

   pins_t pinsRaw;
   pins_t pinsMeta;
   pins_t pinsSync;
   logic enabled;
   logic allSelect;
   logic next_selected;
   logic [sram_capture_pkg::BURST_W-1:0] next_burst;
   logic [sram_capture_pkg::ADDR_W-1:0] capAddr;
   logic [sram_capture_pkg::ADDR_W-1:0] cmdAddr;
   logic [sram_capture_pkg::LANES-1:0] cmdBw_n;
   logic cmdWrite;
   logic pending;
   logic [sram_capture_pkg::LANES-1:0] laneMask;
   sram_capture_pkg::word_t pushWord;
   capture_if link ();

   assign pinsRaw = '{addr: addressPins, data: laneDataPins,
      parity: laneParityPins, bw_n: byteWriteLane_n,
      cs1_n: chipSelectFirst_n, cs2: chipSelectSecond,
      cs3_n: chipSelectThird_n, advance_load: advanceLoad,
      we_n: writeEnable_n, cke_n: clockEnable_n};

   // Two-stage pin synchroniser
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pinsMeta <= '0;
         pinsSync <= '0;
      end else begin
         pinsMeta <= pinsRaw;
         pinsSync <= pinsMeta;
      end
   end

   // Edges count only with clock enable low and room downstream
   assign enabled = !pinsSync.cke_n && link.ready;

   // Selection from all three selects on load cycles
   assign allSelect = !pinsSync.cs1_n && pinsSync.cs2
      && !pinsSync.cs3_n;
   assign next_selected = pinsSync.advance_load ? selected : allSelect;
   assign next_burst = pinsSync.advance_load
      ? burstCount + sram_capture_pkg::BURST_STEP
      : pinsSync.addr[sram_capture_pkg::BURST_W-1:0];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         capAddr <= sram_capture_pkg::ADDR_RST;
         burstCount <= '0;
         selected <= 1'b0;
      end else if (enabled) begin
         capAddr <= pinsSync.addr;
         burstCount <= next_burst;
         selected <= next_selected;
      end
   end

   // Command held one cycle so its lane enables meet the later data
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cmdAddr <= sram_capture_pkg::ADDR_RST;
         cmdBw_n <= sram_capture_pkg::BW_IDLE_N;
         cmdWrite <= 1'b0;
         pending <= 1'b0;
      end else if (enabled) begin
         if (!pinsSync.advance_load) begin
            cmdAddr <= pinsSync.addr;
            cmdWrite <= !pinsSync.we_n;
         end else begin
            cmdAddr <= {cmdAddr[sram_capture_pkg::ADDR_W-1:
               sram_capture_pkg::BURST_W], next_burst};
         end
         cmdBw_n <= pinsSync.bw_n;
         pending <= next_selected;
      end
   end

   // Lane gating of data and parity
   always_comb begin
      laneMask = cmdWrite ? ~cmdBw_n : sram_capture_pkg::LANES_OFF;
      pushWord.addr = cmdAddr;
      pushWord.write = cmdWrite;
      pushWord.laneEn = laneMask;
      pushWord.parity = pinsSync.parity & laneMask;
      pushWord.data = sram_capture_pkg::DATA_RST;
      for (int k = 0; k < sram_capture_pkg::LANES; k++) begin
         if (laneMask[k] || !cmdWrite) begin
            pushWord.data[k*sram_capture_pkg::LANE_BITS +:
               sram_capture_pkg::LANE_BITS] =
               pinsSync.data[k*sram_capture_pkg::LANE_BITS +:
               sram_capture_pkg::LANE_BITS];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         link.valid <= 1'b0;
         link.data <= '0;
      end else if (enabled) begin
         link.valid <= pending;
         link.data <= pushWord;
      end else if (link.ready) begin
         link.valid <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         captureReady <= 1'b0;
      end else begin
         captureReady <= !pinsSync.cke_n && link.ready;
      end
   end

   capture_buffer buffer (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .inPort(link),
      .outWord(capturedWord),
      .outValid(capturedValid),
      .outReady(capturedReady)
   );

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_addr_capture: assert property (enabled |=>
      capAddr == $past(pinsSync.addr))
      else $error("Address not captured");
   a_burst_seed: assert property (enabled && !pinsSync.advance_load |=>
      burstCount == $past(pinsSync.addr[1:0]))
      else $error("Burst counter not seeded");
   a_burst_step: assert property (enabled && pinsSync.advance_load |=>
      burstCount == $past(burstCount) + 2'h1)
      else $error("Burst counter did not step");
   a_lane_mask: assert property (enabled && pending |=>
      link.data.laneEn == ($past(cmdWrite) ? ~$past(cmdBw_n) : 8'h00))
      else $error("Lane enables wrong");
   a_lane_parity: assert property (enabled && pending |=>
      link.data.parity == ($past(pinsSync.parity) & link.data.laneEn))
      else $error("Parity lane gating wrong");
   a_first_select: assert property (enabled && !pinsSync.advance_load
      && pinsSync.cs1_n |=> !selected)
      else $error("First select ignored");
   a_second_select: assert property (enabled && !pinsSync.advance_load
      && !pinsSync.cs2 |=> !selected)
      else $error("Second select ignored");
   a_hold_frozen: assert property (pinsSync.cke_n |=>
      $stable(capAddr) && $stable(burstCount) && $stable(selected))
      else $error("State moved while clock disabled");
   a_burst_keep: assert property (enabled && pinsSync.advance_load |=>
      selected == $past(selected))
      else $error("Selection changed in burst");
   a_write_pair: assert property (enabled && !pinsSync.advance_load
      && allSelect && !pinsSync.we_n |=> pending && cmdWrite
      && cmdBw_n == $past(pinsSync.bw_n))
      else $error("Write command not held");
   a_deselect_drop: assert property (enabled && !pinsSync.advance_load
      && !allSelect |=> !pending && !selected)
      else $error("Deselect cycle kept");
   a_third_select: assert property (enabled && !pinsSync.advance_load
      && pinsSync.cs3_n |=> !selected)
      else $error("Third select ignored");
   a_read_unmasked: assert property (enabled && pending
      && !cmdWrite |=> link.data.laneEn == 8'h00
      && link.data.parity == 8'h00
      && link.data.data == $past(pinsSync.data))
      else $error("Read word masked");
   a_freeze_flag: assert property (pinsSync.cke_n |=> !captureReady)
      else $error("Capture flag high while frozen");

   c_write_load: cover property (enabled && !pinsSync.advance_load && allSelect
      && !pinsSync.we_n);
   c_burst_run: cover property (enabled && pinsSync.advance_load && selected
      ##1 enabled && pinsSync.advance_load);
   c_stall: cover property (capturedValid && !capturedReady
      && !link.ready);
   c_deselect: cover property (enabled && !pinsSync.advance_load && !allSelect);
endmodule // sync_sram_input_capture

// ### hw/sram_capture_pkg.sv
package sram_capture_pkg;
   localparam int ADDR_W = 18;
   localparam int LANES = 8;
   localparam int LANE_BITS = 8;
   localparam int DATA_W = LANES * LANE_BITS;
   localparam int BURST_W = 2;
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
   localparam logic [LANES-1:0] LANES_OFF = 8'h00;
   localparam logic [LANES-1:0] BW_IDLE_N = 8'hFF;
   localparam logic [DATA_W-1:0] DATA_RST = 64'h0000000000000000;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic write;
      logic [LANES-1:0] laneEn;
      logic [LANES-1:0] parity;
      logic [DATA_W-1:0] data;
   } word_t;

   localparam int WORD_W = $bits(word_t);
endpackage

// ### hw/capture_if.sv
`timescale 1ns/1ps
interface capture_if;
   logic valid;
   logic ready;
   sram_capture_pkg::word_t data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface

// ### hw/capture_buffer.sv
`timescale 1ns/1ps
module capture_buffer (
   input wire logic core_clk,
   input wire logic sys_rst,
   capture_if.dst inPort,
   output sram_capture_pkg::word_t outWord,
   output logic outValid,
   input wire logic outReady
);
   sram_capture_pkg::word_t skid;
   logic skidValid;
   logic accept;
   logic drain;

   assign accept = inPort.valid && !skidValid;
   assign drain = !outValid || outReady;

   // Second entry only fills while the output is stalled
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         outValid <= 1'b0;
         skidValid <= 1'b0;
         inPort.ready <= 1'b1;
      end else begin
         if (drain) begin
            if (skidValid) begin
               outValid <= 1'b1;
               skidValid <= 1'b0;
               inPort.ready <= 1'b1;
            end else begin
               outValid <= accept;
            end
         end else if (accept) begin
            skidValid <= 1'b1;
            inPort.ready <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         outWord <= '0;
         skid <= '0;
      end else if (drain) begin
         if (skidValid) begin
            outWord <= skid;
         end else if (accept) begin
            outWord <= inPort.data;
         end
      end else if (accept) begin
         skid <= inPort.data;
      end
   end
endmodule // capture_buffer

// ### tb/sram_ctrl_model.sv
`timescale 1ns/1ps
module sram_ctrl_model (
   input wire logic core_clk,
   output logic [17:0] addressPins,
   output logic [63:0] laneDataPins,
   output logic [7:0] laneParityPins,
   output logic [7:0] byteWriteLane_n,
   output logic [2:0] sel,
   output logic advanceLoad,
   output logic writeEnable_n,
   output logic clockEnable_n
);
   initial begin
      {addressPins, laneDataPins, laneParityPins} = '0;
      byteWriteLane_n = 8'hFF;
      sel = 3'h6;
      {advanceLoad, writeEnable_n, clockEnable_n} = 3'h2;
   end
   // One pin cycle, changed at the falling edge
   task automatic drive(input logic advance_load, input logic [2:0] s,
         input logic [7:0] bw, input logic [17:0] a,
         input logic [63:0] d, input logic [7:0] p, input logic ck,
         input logic w);
      @(negedge core_clk);
      advanceLoad = advance_load;
      sel = s;
      writeEnable_n = w;
      byteWriteLane_n = bw;
      addressPins = a;
      laneDataPins = d;
      laneParityPins = p;
      clockEnable_n = ck;
   endtask
endmodule // sram_ctrl_model

// ### tb/sync_sram_input_capture_bench.sv
`timescale 1ns/1ps
module sync_sram_input_capture_bench;
   typedef logic [sram_capture_pkg::WORD_W-1:0] bits_t;
   localparam logic [2:0] ON = 3'h2;
   localparam logic [63:0] D = 64'h0123456789ABCDEF;
   localparam logic [7:0] P = 8'h5A;
   logic core_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic capturedReady = 1'h1;
   logic [17:0] addr;
   logic [63:0] data;
   logic [7:0] par;
   logic [7:0] bw;
   logic [2:0] sel;
   logic advance_load, weN, ckeN, valid, rdy;
   sram_capture_pkg::word_t word;
   int failures = 0;
   int numChecks = 0;
   int cycles = 0;
   sram_ctrl_model sram_ctrl_model_inst (.core_clk(core_clk),
      .addressPins(addr), .laneDataPins(data), .laneParityPins(par),
      .byteWriteLane_n(bw), .sel(sel), .advanceLoad(advance_load),
      .writeEnable_n(weN), .clockEnable_n(ckeN));
   sync_sram_input_capture sync_sram_input_capture_inst (
      .core_clk(core_clk), .sys_rst(sys_rst), .addressPins(addr),
      .laneDataPins(data), .laneParityPins(par), .byteWriteLane_n(bw),
      .chipSelectFirst_n(sel[2]), .chipSelectSecond(sel[1]),
      .chipSelectThird_n(sel[0]), .advanceLoad(advance_load), .writeEnable_n(weN),
      .clockEnable_n(ckeN), .capturedWord(word), .capturedValid(valid),
      .capturedReady(capturedReady), .captureReady(rdy), .burstCount(),
      .selected());
   task automatic check(input bits_t seen, input bits_t exp);
      numChecks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic bits_t mk(logic [17:0] a, logic [7:0] b,
         logic [63:0] d, logic [7:0] p);
      sram_capture_pkg::word_t w;
      w.addr = a;
      w.write = 1'h1;
      w.laneEn = ~b;
      w.parity = p & ~b;
      for (int k = 0; k < 8; k++) w.data[8*k+:8] = b[k] ? 8'h00 : d[8*k+:8];
      return w;
   endfunction
   task automatic ld(input logic [17:0] a, input logic [7:0] b);
      sram_ctrl_model_inst.drive(1'h0, ON, b, a, ~D, ~P, 1'h0, 1'h0);
   endtask
   task automatic dat(input logic [63:0] d, input logic [7:0] p);
      sram_ctrl_model_inst.drive(1'h0, 3'h6, 8'hFF, 18'h3C3C3, d, p, 1'h0,
         1'h0);
   endtask
   // Wait for one word and compare
   task automatic expect_word(input bits_t exp);
      int n;
      n = 0;
      while (valid !== 1'h1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      check(bits_t'(valid), bits_t'(1'h1));
      check(word, exp);
      @(negedge core_clk);
   endtask
   task automatic no_word();
      repeat (12) begin
         @(negedge core_clk);
         check(bits_t'(valid), bits_t'(1'h0));
      end
   endtask
   task automatic test_lanes();
      for (int k = 0; k < 8; k++) begin
         ld(18'h2ABC0 + 18'(k), 8'hFF ^ (8'h01 << k));
         dat(D, P);
         expect_word(mk(18'h2ABC0 + 18'(k), 8'hFF ^ (8'h01 << k), D, P));
      end
   endtask
   task automatic test_read();
      sram_ctrl_model_inst.drive(1'h0, ON, 8'h00, 18'h0ABCD, ~D, ~P, 1'h0,
         1'h1);
      dat(D, P);
      expect_word(bits_t'({18'h0ABCD, 1'h0, 8'h00, 8'h00, D}));
   endtask
   task automatic test_deselect();
      for (int k = 0; k < 3; k++) begin
         sram_ctrl_model_inst.drive(1'h0, ON ^ (3'h1 << k), 8'h00, 18'h01234,
            ~D, ~P, 1'h0, 1'h0);
         dat(D, P);
         no_word();
      end
   endtask
   task automatic test_burst();
      check(bits_t'(rdy), bits_t'(1'h1));
      capturedReady = 1'h0;
      ld(18'h3FFF7, 8'h00);
      sram_ctrl_model_inst.drive(1'h1, 3'h5, 8'h00, 18'h0, D, P, 1'h0,
         1'h0);
      dat(~D, ~P);
      repeat (10) @(negedge core_clk);
      check(bits_t'(rdy), bits_t'(1'h0));
      capturedReady = 1'h1;
      expect_word(mk(18'h3FFF7, 8'h00, D, P));
      expect_word(mk(18'h3FFF4, 8'h00, ~D, ~P));
   endtask
   task automatic test_freeze();
      ld(18'h15555, 8'h0F);
      sram_ctrl_model_inst.drive(1'h0, ON, 8'h00, 18'h3AAAA, 64'h0, 8'hFF,
         1'h1, 1'h0);
      dat(D, P);
      expect_word(mk(18'h15555, 8'h0F, D, P));
      no_word();
   endtask
   task automatic complete_run();
      if (failures == 0 && numChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         complete_run();
      end
   end
   initial begin
      repeat (16) @(negedge core_clk);
      sys_rst = 1'h0;
      repeat (4) @(negedge core_clk);
      test_lanes();
      test_read();
      test_deselect();
      test_burst();
      test_freeze();
      complete_run();
   end
endmodule // sync_sram_input_capture_bench
